// >>> logic/main_cpu_status_control_consts.svh
// Offsets, field positions and reset values of the core status bank
`ifndef MAIN_CPU_STATUS_CONTROL_CONSTS_SVH
`define MAIN_CPU_STATUS_CONTROL_CONSTS_SVH
`define OFS_FPU_STATUS_CONTROL 8'h08
`define OFS_PARALLEL_CORE_ERROR 8'h0a
`define OFS_BLOCK_MOVE_REQUEST 8'h0d
`define OFS_FAULT_BASE 8'h10
`define FAULT_REG_COUNT 5
`define OFS_ICACHE_AGE_ORDER 8'h38
`define OFS_DCACHE_AGE_ORDER 8'h39
`define OFS_ICACHE_TAG_BASE 8'h40
`define OFS_DCACHE_TAG_BASE 8'h50
`define FP_FLAGS_LSB 0
`define FP_MUL_OVF_BIT 5
`define FP_RM_LSB 6
`define FP_PD_LSB 8
`define FP_EXP_LSB 10
`define FP_OPCODE_LSB 12
`define FP_VM_BIT 17
`define FP_FS_BIT 18
`define FP_SM_BIT 19
`define FP_DRM_LSB 20
`define FP_STICKY_LSB 22
`define FP_DEST_LSB 27
`define PCE_FAULT_LSB 0
`define PCE_ILLEGAL_LSB 8
`define PCE_HALT_LSB 16
`define BMR_SUBMIT_BIT 0
`define BMR_QUEUED_BIT 1
`define BMR_SUSPEND_BIT 2
`define BMR_FOREGROUND_BIT 3
`define BMR_URGENT_BIT 4
`define AGE_ORDER_RESET 8'he4
`define TAG_ADDR_LSB 16
`define TAG_DIRTY_LSB 8
`define TAG_PRESENT_LSB 0
`define SET_INDEX_LSB 8
`define SUB_INDEX_LSB 5
`endif

// >>> logic/main_cpu_status_control_pkg.sv
// Types shared by the core status and control bank
package main_cpu_status_control_pkg;
    typedef enum logic [1:0] {
        round_nearest, round_zero, round_pos_inf, round_neg_inf
    } round_mode_e;
    typedef enum logic [1:0] {
        fmt_single, fmt_double, fmt_signed_int, fmt_unsigned_int
    } result_format_e;
endpackage : main_cpu_status_control_pkg

// >>> logic/main_cpu_status_control_regs.sv
// Status and control register bank of the main processor core
//
// Local design decision: the strobed register port.
`timescale 1ns/10ps
`include "main_cpu_status_control_consts.svh"
module main_cpu_status_control_regs
    import main_cpu_status_control_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    input wire logic fpu_done,
    input wire logic [4:0] fpu_dest,
    input wire logic [4:0] fpu_opcode,
    input wire logic [1:0] fpu_exp_hi,
    input wire logic [1:0] fpu_round,
    input wire logic [1:0] fpu_precision,
    input wire logic [5:0] fpu_flags,
    input wire logic [1:0] core_halted,
    input wire logic [1:0] core_illegal,
    input wire logic [1:0] core_fault_type,
    input wire logic block_move_done,
    output logic block_move_submit,
    output logic block_move_queued,
    output logic block_move_suspend,
    output logic block_move_foreground,
    output logic block_move_urgent,
    output round_mode_e fpu_round_mode,
    output result_format_e fpu_result_format,
    output logic fpu_sequential_select,
    output logic fpu_stall,
    output logic fpu_vector_fast,
    input wire logic fault_capture,
    input wire logic [31:0] fault_word [`FAULT_REG_COUNT],
    input wire logic [1:0] cache_fill,
    input wire logic [1:0] cache_access,
    input wire logic [1:0] cache_write,
    input wire logic [31:0] cache_addr [2]
);

    generate
        if (ADDR_W < 7) begin : gen_bad_width
            $error("ADDR_W too small for the register map");
        end
    endgenerate

    logic [4:0] fpu_ctrl_reg;
    logic [4:0] fpu_sticky_reg;
    logic [4:0] fpu_dest_reg;
    logic [16:0] fpu_last_reg;
    logic [31:0] fpu_status_word;
    logic [31:0] parallel_core_error_reg;
    logic [4:0] block_move_ctrl_reg;
    logic [31:0] fault_reg [`FAULT_REG_COUNT];
    logic [31:0] age_rd [2];
    logic [31:0] tag_rd [2];
    logic [7:0] wr_ofs;
    logic fpu_status_control_wr;
    logic bmr_wr;

    assign wr_ofs = 8'(reg_addr);
    assign fpu_status_control_wr = reg_write && (wr_ofs == `OFS_FPU_STATUS_CONTROL);
    assign bmr_wr = reg_write && (wr_ofs == `OFS_BLOCK_MOVE_REQUEST);

    // Status word as software sees it, each field owned by one process
    assign fpu_status_word = {fpu_dest_reg, fpu_sticky_reg, fpu_ctrl_reg,
                              fpu_last_reg};

    function automatic round_mode_e decode_round(input logic [1:0] code);
        round_mode_e r;
        r = round_nearest;
        unique case (code)
            2'h0: r = round_nearest;
            2'h1: r = round_zero;
            2'h2: r = round_pos_inf;
            2'h3: r = round_neg_inf;
        endcase
        return r;
    endfunction : decode_round

    function automatic result_format_e decode_format(input logic [1:0] code);
        result_format_e f;
        f = fmt_single;
        unique case (code)
            2'h0: f = fmt_single;
            2'h1: f = fmt_double;
            2'h2: f = fmt_signed_int;
            2'h3: f = fmt_unsigned_int;
        endcase
        return f;
    endfunction : decode_format

    // FPU control bits
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fpu_ctrl_reg <= 5'h00;
        end else if (fpu_status_control_wr) begin
            fpu_ctrl_reg <= reg_wdata[21:17];
        end
    end

    // Sticky exception flags
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fpu_sticky_reg <= 5'h00;
        end else begin
            fpu_sticky_reg <=
                (fpu_status_control_wr ? reg_wdata[26:22] : fpu_sticky_reg)
                | (fpu_done ? fpu_flags[4:0] : 5'h00);
        end
    end

    // Last-instruction status, never written by software
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fpu_dest_reg <= 5'h00;
            fpu_last_reg <= 17'h00000;
        end else if (fpu_done) begin
            fpu_dest_reg <= fpu_dest;
            fpu_last_reg[16:12] <= fpu_opcode;
            fpu_last_reg[11:10] <= fpu_exp_hi;
            fpu_last_reg[9:8] <= fpu_precision;
            fpu_last_reg[7:6] <= fpu_round;
            fpu_last_reg[5:0] <= fpu_flags;
        end
    end

    // Decoded FPU modes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fpu_round_mode <= round_nearest;
            fpu_result_format <= fmt_single;
            fpu_sequential_select <= 1'b0;
            fpu_stall <= 1'b0;
            fpu_vector_fast <= 1'b0;
        end else begin
            if (fpu_status_control_wr) begin
                fpu_round_mode <= decode_round(reg_wdata[21:20]);
                fpu_sequential_select <= reg_wdata[`FP_SM_BIT];
                fpu_stall <= reg_wdata[`FP_FS_BIT];
                fpu_vector_fast <= reg_wdata[`FP_VM_BIT];
            end
            if (fpu_done) begin
                fpu_result_format <= decode_format(fpu_precision);
            end
        end
    end

    // Parallel-core error capture
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            parallel_core_error_reg <= 32'h00000000;
        end else begin
            // Halted, illegal and fault type per core
            parallel_core_error_reg <= 32'h00000000;
            parallel_core_error_reg[17:16] <= core_halted;
            parallel_core_error_reg[9:8] <= core_illegal;
            parallel_core_error_reg[1:0] <= core_fault_type;
        end
    end

    // Block-move request controls
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            block_move_ctrl_reg <= 5'h00;
            block_move_submit <= 1'b0;
        end else begin
            // Submit pulse on write of one
            block_move_submit <= bmr_wr && reg_wdata[`BMR_SUBMIT_BIT];
            if (bmr_wr) begin
                block_move_ctrl_reg <= reg_wdata[4:0];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            block_move_queued <= 1'b0;
        end else if (bmr_wr && reg_wdata[`BMR_SUBMIT_BIT]) begin
            block_move_queued <= 1'b1;
        end else if (block_move_done) begin
            block_move_queued <= 1'b0;
        end
    end

    assign block_move_suspend = block_move_ctrl_reg[`BMR_SUSPEND_BIT];
    assign block_move_foreground = block_move_ctrl_reg[`BMR_FOREGROUND_BIT];
    assign block_move_urgent = block_move_ctrl_reg[`BMR_URGENT_BIT];

    // Memory fault capture
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < `FAULT_REG_COUNT; i++) begin
                fault_reg[i] <= 32'h00000000;
            end
        end else if (fault_capture) begin
            for (int i = 0; i < `FAULT_REG_COUNT; i++) begin
                fault_reg[i] <= fault_word[i];
            end
        end
    end

    // One instance per cache: 0 instruction, 1 data
    // Separate age order per cache
    for (genvar c = 0; c < 2; c++) begin : gen_cache
        // Full tag kept apart from the flags so dirty bits cannot alias it
        logic [21:0] tag_addr_reg [16];
        logic [7:0] present_reg [16];
        logic [7:0] dirty_reg [16];
        logic dirty_set;
        logic [7:0] age_reg [4];
        logic [1:0] set_idx;
        logic [2:0] sub_idx;
        logic [21:0] tag_val;
        logic hit;
        logic [1:0] hit_blk;
        logic [1:0] use_blk;
        logic [3:0] ent;
        logic [7:0] age_new;
        logic [3:0] rd_idx;

        assign set_idx = cache_addr[c][9:8];
        assign sub_idx = cache_addr[c][7:5];
        assign tag_val = cache_addr[c][31:10];
        assign ent = {set_idx, use_blk};

        always_comb begin
            hit = 1'b0;
            hit_blk = 2'h0;
            for (int b = 0; b < 4; b++) begin
                if (tag_addr_reg[{set_idx, 2'(b)}] == tag_val &&
                    |present_reg[{set_idx, 2'(b)}]) begin
                    hit = 1'b1;
                    hit_blk = 2'(b);
                end
            end
            // Miss replaces the oldest block of the set
            use_blk = hit ? hit_blk : age_reg[set_idx][7:6];
        end

        // Move used block to newest, keep others in order
        always_comb begin
            logic found;
            found = 1'b0;
            age_new = age_reg[set_idx];
            age_new[1:0] = use_blk;
            for (int p = 0; p < 3; p++) begin
                if (age_reg[set_idx][2*p +: 2] == use_blk) begin
                    found = 1'b1;
                end
                if (!found) begin
                    age_new[2*p+2 +: 2] = age_reg[set_idx][2*p +: 2];
                end
            end
        end

        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                for (int s = 0; s < 4; s++) begin
                    age_reg[s] <= `AGE_ORDER_RESET;
                end
            end else if (cache_fill[c] || (cache_access[c] && hit)) begin
                age_reg[set_idx] <= age_new;
            end
        end

        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                for (int e = 0; e < 16; e++) begin
                    tag_addr_reg[e] <= 22'h000000;
                    present_reg[e] <= 8'h00;
                end
            end else if (cache_fill[c]) begin
                // A fill loads exactly one subblock
                if (hit) begin
                    present_reg[ent][sub_idx] <= 1'b1;
                end else begin
                    tag_addr_reg[ent] <= tag_val;
                    present_reg[ent] <= 8'h01 << sub_idx;
                end
            end
        end

        // Only the data cache marks written subblocks
        assign dirty_set = (c == 1) && cache_access[c] && cache_write[c] && hit;

        // Dirty flags; a replaced block starts clean
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                for (int e = 0; e < 16; e++) begin
                    dirty_reg[e] <= 8'h00;
                end
            end else if (cache_fill[c] && !hit) begin
                dirty_reg[ent] <= 8'h00;
            end else if (dirty_set) begin
                dirty_reg[ent][sub_idx] <= 1'b1;
            end
        end

        assign rd_idx = 4'(reg_addr);
        // Tag word shows address bits 31:16; matching uses the whole tag
        assign tag_rd[c] = {tag_addr_reg[rd_idx][21:6], dirty_reg[rd_idx],
                            present_reg[rd_idx]};
        assign age_rd[c] = {age_reg[3], age_reg[2], age_reg[1], age_reg[0]};
    end

    // Read port: data stand the cycle after the strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_read) begin
            reg_rdata <= 32'h00000000;
            if (wr_ofs == `OFS_FPU_STATUS_CONTROL) begin
                reg_rdata <= fpu_status_word;
            end else if (wr_ofs == `OFS_PARALLEL_CORE_ERROR) begin
                reg_rdata <= parallel_core_error_reg;
            end else if (wr_ofs == `OFS_BLOCK_MOVE_REQUEST) begin
                reg_rdata <= {27'h0000000, block_move_ctrl_reg[4:2],
                              block_move_queued, 1'b0};
            end else if (wr_ofs >= `OFS_FAULT_BASE &&
                         wr_ofs < `OFS_FAULT_BASE + 8'(`FAULT_REG_COUNT)) begin
                reg_rdata <= fault_reg[3'(wr_ofs - `OFS_FAULT_BASE)];
            end else if (wr_ofs == `OFS_ICACHE_AGE_ORDER) begin
                reg_rdata <= age_rd[0];
            end else if (wr_ofs == `OFS_DCACHE_AGE_ORDER) begin
                reg_rdata <= age_rd[1];
            end else if (wr_ofs[7:4] == `OFS_ICACHE_TAG_BASE >> 4) begin
                reg_rdata <= tag_rd[0];
            end else if (wr_ofs[7:4] == `OFS_DCACHE_TAG_BASE >> 4) begin
                reg_rdata <= tag_rd[1];
            end
        end
    end

endmodule : main_cpu_status_control_regs

// >>> tb/main_cpu_status_control_regs_chk.sv
// Port assertions for the core status and control bank
`timescale 1ns/10ps
module main_cpu_status_control_regs_chk
    import main_cpu_status_control_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic fpu_done,
    input wire logic [1:0] fpu_precision,
    input wire logic block_move_done,
    input wire logic block_move_submit,
    input wire logic block_move_queued,
    input wire logic block_move_suspend,
    input wire logic block_move_foreground,
    input wire logic block_move_urgent,
    input wire round_mode_e fpu_round_mode,
    input wire result_format_e fpu_result_format,
    input wire logic fpu_sequential_select,
    input wire logic fpu_stall,
    input wire logic fpu_vector_fast
);
    logic bmw;
    logic fpw;
    logic sub_w;
    assign bmw = reg_write && reg_addr == 8'h0d;
    assign fpw = reg_write && reg_addr == 8'h08;
    assign sub_w = bmw && reg_wdata[0];
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    chk_submit_follows: assert property (sub_w |=> block_move_submit)
        else $error("submit pulse missing");
    chk_submit_cause: assert property (
        block_move_submit |-> $past(sub_w)) else $error("stray submit");
    chk_queued_on_submit: assert property (
        block_move_submit |-> block_move_queued) else $error("queued low");
    chk_queued_clear: assert property (
        block_move_queued && block_move_done && !sub_w |=> !block_move_queued)
        else $error("queued not cleared");
    chk_queued_hold: assert property (
        block_move_queued && !block_move_done |=> block_move_queued)
        else $error("queued dropped");
    chk_suspend_bit: assert property (
        bmw |=> block_move_suspend == $past(reg_wdata[2]))
        else $error("suspend wrong");
    chk_priority_bits: assert property (
        bmw |=> {block_move_urgent, block_move_foreground}
        == $past(reg_wdata[4:3])) else $error("priority wrong");
    chk_control_bits: assert property (
        fpw |=> {fpu_round_mode, fpu_sequential_select, fpu_stall,
        fpu_vector_fast} == $past(reg_wdata[21:17]))
        else $error("control bits wrong");
    chk_format_capture: assert property (
        fpu_done |=> fpu_result_format == $past(fpu_precision))
        else $error("format wrong");
endmodule : main_cpu_status_control_regs_chk
bind main_cpu_status_control_regs main_cpu_status_control_regs_chk
    #(.ADDR_W(ADDR_W)) chk (.clk, .rst, .reg_addr, .reg_wdata, .reg_write,
    .fpu_done, .fpu_precision, .block_move_done, .block_move_submit,
    .block_move_queued, .block_move_suspend, .block_move_foreground,
    .block_move_urgent, .fpu_round_mode, .fpu_result_format,
    .fpu_sequential_select, .fpu_stall, .fpu_vector_fast);

// >>> tb/main_cpu_status_control_regs_tb.sv
// Self-checking bench for the core status and control bank
`timescale 1ns/10ps
module main_cpu_status_control_regs_tb
    import main_cpu_status_control_pkg::*;
;
    logic clk, rst, reg_write, reg_read, fpu_done, block_move_done;
    logic fault_capture, block_move_submit, block_move_queued;
    logic block_move_suspend, block_move_foreground, block_move_urgent;
    logic fpu_sequential_select, fpu_stall, fpu_vector_fast;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, fword;
    logic [4:0] fpu_dest, fpu_opcode;
    logic [1:0] fpu_exp_hi, fpu_round, fpu_precision, pat;
    logic [1:0] core_halted, core_illegal, core_fault_type;
    logic [1:0] cache_fill, cache_access, cache_write;
    logic [5:0] fpu_flags;
    logic [31:0] fault_word [5];
    logic [31:0] cache_addr [2];
    round_mode_e fpu_round_mode;
    result_format_e fpu_result_format;
    int errors, checked, cycles;
    main_cpu_status_control_regs #(.ADDR_W(8)) DUT (.clk, .rst,
        .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
        .fpu_done, .fpu_dest, .fpu_opcode, .fpu_exp_hi, .fpu_round,
        .fpu_precision, .fpu_flags, .core_halted, .core_illegal,
        .core_fault_type, .block_move_done, .block_move_submit,
        .block_move_queued, .block_move_suspend, .block_move_foreground,
        .block_move_urgent, .fpu_round_mode, .fpu_result_format,
        .fpu_sequential_select, .fpu_stall, .fpu_vector_fast,
        .fault_capture, .fault_word, .cache_fill, .cache_access,
        .cache_write, .cache_addr);
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 check(reg_rdata, exp);
    endtask : rdc
    task automatic finish_test();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 4000) begin
            errors++;
            finish_test();
        end
    end
    initial begin
        {rst, reg_write, reg_read, fpu_done, block_move_done} = 5'h10;
        {fault_capture, cache_fill, cache_access, cache_write} = 7'h0;
        {reg_addr, reg_wdata, fpu_dest, fpu_opcode, fpu_flags} = '0;
        {fpu_exp_hi, fpu_round, fpu_precision} = 6'h0;
        {core_halted, core_illegal, core_fault_type} = 6'h0;
        foreach (fault_word[k]) fault_word[k] = 32'h0;
        cache_addr[0] = 32'h0;
        cache_addr[1] = 32'h0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rdc(8'h08, 32'h0);
        rdc(8'h38, 32'he4e4e4e4);
        rdc(8'h20, 32'h0);
        $display("test reset done");
        wr(8'h08, 32'hffffffff);
        rdc(8'h08, 32'h07fe0000);
        check({fpu_round_mode, fpu_sequential_select, fpu_stall}, 4'hf);
        wr(8'h08, 32'h0);
        @(posedge clk);
        {fpu_dest, fpu_opcode, fpu_flags} <= {5'h15, 5'h0a, 6'h2b};
        {fpu_exp_hi, fpu_round, fpu_precision} <= {2'b10, 2'b01, 2'b10};
        fpu_done <= 1'b1;
        @(posedge clk);
        fpu_done <= 1'b0;
        fword = {5'h15, 5'h0b, 5'h00, 5'h0a, 2'b10, 2'b10, 2'b01, 6'h2b};
        rdc(8'h08, fword);
        check(fpu_result_format, 32'h2);
        @(posedge clk);
        fpu_flags <= 6'h0;
        fpu_done <= 1'b1;
        @(posedge clk);
        fpu_done <= 1'b0;
        rdc(8'h08, fword & 32'hffffffc0);
        wr(8'h08, 32'h0);
        rdc(8'h08, fword & 32'hf83fffc0);
        $display("test fpu done");
        for (int i = 0; i < 2; i++) begin
            pat = 2'b01 << i;
            @(posedge clk);
            core_halted <= pat;
            core_illegal <= ~pat;
            core_fault_type <= pat;
            rdc(8'h0a, {14'h0, pat, 6'h0, ~pat, 6'h0, pat});
        end
        $display("test core error done");
        wr(8'h0d, 32'h1);
        #1 check(block_move_submit, 32'h1);
        check(block_move_queued, 32'h1);
        rdc(8'h0d, 32'h2);
        wr(8'h0d, 32'h1c);
        rdc(8'h0d, 32'h1e);
        check({block_move_urgent, block_move_foreground}, 32'h3);
        @(posedge clk);
        block_move_done <= 1'b1;
        @(posedge clk);
        block_move_done <= 1'b0;
        rdc(8'h0d, 32'h1c);
        $display("test block move done");
        @(posedge clk);
        foreach (fault_word[k]) fault_word[k] <= 32'ha5000000 + k;
        fault_capture <= 1'b1;
        @(posedge clk);
        fault_capture <= 1'b0;
        wr(8'h10, 32'h0);
        for (int k = 0; k < 5; k++) begin
            rdc(8'(8'h10 + k), 32'ha5000000 + k);
        end
        $display("test fault regs done");
        @(posedge clk);
        cache_addr[0] <= 32'h10040;
        cache_addr[1] <= 32'h10040;
        cache_fill <= 2'b11;
        @(posedge clk);
        cache_fill <= 2'b00;
        cache_access <= 2'b10;
        cache_write <= 2'b10;
        @(posedge clk);
        cache_access <= 2'b00;
        cache_write <= 2'b00;
        rdc(8'h43, 32'h10004);
        rdc(8'h53, 32'h10404);
        rdc(8'h38, 32'he4e4e493);
        rdc(8'h39, 32'he4e4e493);
        $display("test cache done");
        finish_test();
    end
endmodule : main_cpu_status_control_regs_tb
